// file: design/pixel_port_pkg.sv
// Package with constants, register map and carrier types of the pixel port control block.
package pixel_port_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_SYNC_CFG = 8'h0F;
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_PHASE = 8'h11;
  localparam logic [7:0] IDX_PERIOD = 8'h12;
  localparam logic [7:0] IDX_CLAMP_DLY = 8'h13;
  localparam logic [7:0] IDX_CLAMP_DUR = 8'h14;
  localparam logic [7:0] IDX_LSYNC_WID = 8'h15;
  localparam logic [7:0] IDX_STATUS = 8'h16;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int POS_SYNC_POL = 7;
  localparam int POS_DUAL = 0;
  localparam int POS_PAR = 1;
  localparam int POS_EXT_CLAMP = 2;
  localparam int POS_CLAMP_SENSE = 3;
  localparam int POS_EXT_CLK = 4;
  localparam int POS_HOLD_SENSE = 5;
  localparam int POS_SLICER_SEL = 6;
  localparam int POS_LSYNC_POL = 7;

  // ****************************************************************
  // Values after reset, minimum period and sizes.
  // ****************************************************************
  localparam logic RST_SYNC_POL = 1'b0;
  localparam logic [7:0] RST_CONTROL = 8'h20;
  localparam logic [2:0] RST_PHASE = 3'h0;
  localparam logic [7:0] RST_PERIOD = 8'h04;
  localparam logic [7:0] RST_CLAMP_DLY = 8'h04;
  localparam logic [7:0] RST_CLAMP_DUR = 8'h08;
  localparam logic [7:0] RST_LSYNC_WID = 8'h08;
  localparam logic [7:0] MIN_PERIOD = 8'h02;
  localparam int PHASE_STEPS = 8;
  localparam int PIN_COUNT = 6;

  // ****************************************************************
  // Bus answers.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_t;

  typedef struct packed {
    logic hsync;
    logic clamp;
    logic holdover;
    logic ext_clock;
    logic invert;
    logic green_sync;
  } pins_t;

  typedef enum logic [1:0] {
    CLAMP_IDLE = 2'b00,
    CLAMP_DELAY = 2'b01,
    CLAMP_HOLD = 2'b10
  } clamp_state_t;

endpackage

// file: design/pixel_port_control.sv
// Pixel port control: sync edge, clamp window, clock choice and output port formatting.
`timescale 1ns/100ps
// Notes on behaviour
// - Leading edge of horizontal sync times generator and line sync; trailing edge starts the internal clamp window.
// - Horizontal sync sense is bit 7 of register index 0Fh.
// - Sense 0 makes the falling edge active, sense 1 the rising edge.
// - External clamp pin is honoured only when its enable is 1; enable resets 0.
// - Clamp disabled externally: window counted as delay then duration from trailing edge.
// - A clamp sense bit selects the active level of the clamp pin.
// - During holdover the clock generator stops resyncing and keeps frequency and phase.
// - Holdover sense bit selects the active level; it resets to 1.
// - External clock select 1 uses the external clock pin; all else works as usual.
// - Phase adjustment still applies with the external clock.
// - Invert input moves the sampling point by half a pixel period.
// - Each colour port is eight bits wide with bit 7 most significant.
// - Single port mode: every pixel on port A, port B released.
// - Parallel dual mode: two pixels on A and B together every second pixel.
// - Interleaved dual mode: pixels alternate ports, one port updated per pixel.
// - In dual modes the first pixel after sync goes to A, then B, alternating.
// - Fixed latency; phase shifts data, strobe and line sync together.
// - Complementary strobe pair comes from the pixel sampling tick.
// - Strobe runs at pixel rate single, half pixel rate in dual modes.
// - Line sync output copies the leading edge, with set polarity and width.
// - Slicer output selects green sync comparator or delayed raw horizontal sync.
module pixel_port_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins, asynchronous to aclk
  input wire pixel_port_pkg::pins_t pins_in,
  // Converted pixel from the converters, on aclk
  input wire pixel_port_pkg::pixel_t pixel_in,
  // Output ports and strobes
  output pixel_port_pkg::pixel_t port_a,
  output pixel_port_pkg::pixel_t port_b,
  output logic port_b_oe,
  output logic output_strobe_clock,
  output logic output_strobe_clock_n,
  output logic line_sync_output,
  output logic green_sync_slicer_output,
  // Analog front end control
  output logic sample_strobe,
  output logic clamp_window
);
  import pixel_port_pkg::*;

  // ****************************************************************
  // Registers and the bus slave.
  // ****************************************************************
  logic sync_pol_q;
  logic [7:0] control_q;
  logic [2:0] phase_q;
  logic [7:0] period_q;
  logic [7:0] clamp_dly_q;
  logic [7:0] clamp_dur_q;
  logic [7:0] lsync_wid_q;
  logic aw_full_q, w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] status_word;

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = reg_index(addr);
    mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (idx >= IDX_SYNC_CFG) && (idx <= IDX_STATUS);
  endfunction

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (aw_full_q && w_full_q) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Only the low byte lane holds register bits; other lanes are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_pol_q <= RST_SYNC_POL;
      control_q <= RST_CONTROL;
      phase_q <= RST_PHASE;
      period_q <= RST_PERIOD;
      clamp_dly_q <= RST_CLAMP_DLY;
      clamp_dur_q <= RST_CLAMP_DUR;
      lsync_wid_q <= RST_LSYNC_WID;
    end else if (aw_full_q && w_full_q && wstrb_q[0] && mapped(awaddr_q)) begin
      unique case (reg_index(awaddr_q))
        IDX_SYNC_CFG: sync_pol_q <= wdata_q[POS_SYNC_POL];
        IDX_CONTROL: control_q <= wdata_q[7:0];
        IDX_PHASE: phase_q <= wdata_q[2:0];
        IDX_PERIOD: period_q <= (wdata_q[7:0] < MIN_PERIOD) ? MIN_PERIOD : wdata_q[7:0];
        IDX_CLAMP_DLY: clamp_dly_q <= wdata_q[7:0];
        IDX_CLAMP_DUR: clamp_dur_q <= wdata_q[7:0];
        IDX_LSYNC_WID: lsync_wid_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aw_full_q && w_full_q) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      if (mapped(s_axi_araddr)) begin
        unique case (reg_index(s_axi_araddr))
          IDX_SYNC_CFG: s_axi_rdata <= {24'h00_0000, sync_pol_q, 7'h00};
          IDX_CONTROL: s_axi_rdata <= {24'h00_0000, control_q};
          IDX_PHASE: s_axi_rdata <= {29'h0000_0000, phase_q};
          IDX_PERIOD: s_axi_rdata <= {24'h00_0000, period_q};
          IDX_CLAMP_DLY: s_axi_rdata <= {24'h00_0000, clamp_dly_q};
          IDX_CLAMP_DUR: s_axi_rdata <= {24'h00_0000, clamp_dur_q};
          IDX_LSYNC_WID: s_axi_rdata <= {24'h00_0000, lsync_wid_q};
          IDX_STATUS: s_axi_rdata <= status_word;
          default: ;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic dual, par, ext_clamp_en, clamp_sense, ext_sel, hold_sense, slicer_sel, lsync_pol;
  assign dual = control_q[POS_DUAL];
  assign par = control_q[POS_PAR];
  assign ext_clamp_en = control_q[POS_EXT_CLAMP];
  assign clamp_sense = control_q[POS_CLAMP_SENSE];
  assign ext_sel = control_q[POS_EXT_CLK];
  assign hold_sense = control_q[POS_HOLD_SENSE];
  assign slicer_sel = control_q[POS_SLICER_SEL];
  assign lsync_pol = control_q[POS_LSYNC_POL];

  // ****************************************************************
  // Pin synchronisers and edge detection.
  // ****************************************************************
  logic [PIN_COUNT-1:0] meta_q, sync_q;
  pins_t pin_s;
  logic hs_prev_q, ext_prev_q;

  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pins_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign pin_s = sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      hs_prev_q <= pin_s.hsync;
      ext_prev_q <= pin_s.ext_clock;
    end
  end

  logic hs_rise, hs_fall, lead_edge, trail_edge, hold_act;
  assign hs_rise = pin_s.hsync && !hs_prev_q;
  assign hs_fall = !pin_s.hsync && hs_prev_q;
  assign lead_edge = sync_pol_q ? hs_rise : hs_fall;
  assign trail_edge = sync_pol_q ? hs_fall : hs_rise;
  assign hold_act = (pin_s.holdover == hold_sense);

  // ****************************************************************
  // Pixel tick: sync-tracking generator or external clock pin.
  // ****************************************************************
  logic [7:0] gen_cnt_q;
  logic gen_wrap, tick_int, tick_ext, raw_tick;
  assign gen_wrap = (gen_cnt_q >= period_q - 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_cnt_q <= 8'h00;
    end else if (lead_edge && !hold_act) begin
      gen_cnt_q <= 8'h00;
    end else if (gen_wrap) begin
      gen_cnt_q <= 8'h00;
    end else begin
      gen_cnt_q <= gen_cnt_q + 8'h01;
    end
  end

  // Inversion picks the opposite half of the pixel period.
  assign tick_int = (gen_cnt_q == (pin_s.invert ? (period_q >> 1) : 8'h00));
  assign tick_ext = pin_s.invert ? (ext_prev_q && !pin_s.ext_clock) : (!ext_prev_q && pin_s.ext_clock);
  assign raw_tick = ext_sel ? tick_ext : tick_int;

  // One delay line carries tick and both sync edges so the phase moves them together.
  logic [2:0] dly_q [0:PHASE_STEPS-1];
  logic [2:0] dly_out;
  logic tick, lead_d, trail_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < PHASE_STEPS; k++) begin
        dly_q[k] <= 3'h0;
      end
    end else begin
      dly_q[0] <= {raw_tick, lead_edge, trail_edge};
      for (int k = 1; k < PHASE_STEPS; k++) begin
        dly_q[k] <= dly_q[k-1];
      end
    end
  end

  assign dly_out = (phase_q == 3'h0) ? {raw_tick, lead_edge, trail_edge} : dly_q[phase_q - 3'h1];
  assign tick = dly_out[2];
  assign lead_d = dly_out[1];
  assign trail_d = dly_out[0];
  assign sample_strobe = tick;

  // ****************************************************************
  // Output port formatting.
  // ****************************************************************
  logic sel_b_q, first_b;
  pixel_t hold_q;
  assign first_b = lead_d ? 1'b0 : sel_b_q;
  assign port_b_oe = dual;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_b_q <= 1'b0;
    end else if (tick && dual) begin
      sel_b_q <= !first_b;
    end else if (lead_d) begin
      sel_b_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a <= '0;
      port_b <= '0;
      hold_q <= '0;
    end else if (tick) begin
      if (!dual) begin
        port_a <= pixel_in;
      end else if (par) begin
        if (!first_b) begin
          hold_q <= pixel_in;
        end else begin
          port_a <= hold_q;
          port_b <= pixel_in;
        end
      end else if (!first_b) begin
        port_a <= pixel_in;
      end else begin
        port_b <= pixel_in;
      end
    end
  end

  // ****************************************************************
  // Output strobe pair and line sync.
  // ****************************************************************
  logic strobe_q;
  logic [7:0] strobe_cnt_q;
  logic [7:0] lsync_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      strobe_cnt_q <= 8'h00;
    end else if (dual) begin
      strobe_cnt_q <= 8'h00;
      if (tick) begin
        strobe_q <= !strobe_q;
      end
    end else if (tick) begin
      strobe_q <= 1'b1;
      strobe_cnt_q <= period_q >> 1;
    end else if (strobe_cnt_q > 8'h01) begin
      strobe_cnt_q <= strobe_cnt_q - 8'h01;
    end else begin
      strobe_cnt_q <= 8'h00;
      strobe_q <= 1'b0;
    end
  end
  assign output_strobe_clock = strobe_q;
  assign output_strobe_clock_n = !strobe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lsync_cnt_q <= 8'h00;
    end else if (lead_d) begin
      lsync_cnt_q <= lsync_wid_q;
    end else if (tick && lsync_cnt_q != 8'h00) begin
      lsync_cnt_q <= lsync_cnt_q - 8'h01;
    end
  end
  assign line_sync_output = (lsync_cnt_q != 8'h00) ? lsync_pol : !lsync_pol;

  // ****************************************************************
  // Clamp window and slicer output.
  // ****************************************************************
  clamp_state_t clamp_state_q;
  logic [7:0] clamp_cnt_q;
  logic int_clamp;
  assign int_clamp = (clamp_state_q == CLAMP_HOLD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clamp_state_q <= CLAMP_IDLE;
      clamp_cnt_q <= 8'h00;
    end else if (trail_d) begin
      clamp_state_q <= CLAMP_DELAY;
      clamp_cnt_q <= clamp_dly_q;
    end else if (tick) begin
      unique case (clamp_state_q)
        CLAMP_IDLE: ;
        CLAMP_DELAY: begin
          if (clamp_cnt_q == 8'h00) begin
            clamp_state_q <= (clamp_dur_q == 8'h00) ? CLAMP_IDLE : CLAMP_HOLD;
            clamp_cnt_q <= clamp_dur_q - 8'h01;
          end else begin
            clamp_cnt_q <= clamp_cnt_q - 8'h01;
          end
        end
        CLAMP_HOLD: begin
          if (clamp_cnt_q == 8'h00) begin
            clamp_state_q <= CLAMP_IDLE;
          end else begin
            clamp_cnt_q <= clamp_cnt_q - 8'h01;
          end
        end
        default: clamp_state_q <= CLAMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clamp_window <= 1'b0;
      green_sync_slicer_output <= 1'b0;
    end else begin
      clamp_window <= ext_clamp_en ? (pin_s.clamp == clamp_sense) : int_clamp;
      green_sync_slicer_output <= slicer_sel ? hs_prev_q : pin_s.green_sync;
    end
  end

  assign status_word = {24'h00_0000, 3'h0, sel_b_q, int_clamp, hold_act, pin_s.hsync, ext_sel};

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_line_start;
    dual && lead_d && !tick;
  endsequence
  sequence s_pick_a;
    dual && !par && tick && !first_b;
  endsequence

  chk_edge_sense: assert property (lead_edge |-> pin_s.hsync == sync_pol_q)
    else $error("active edge has wrong direction");
  chk_hold_track: assert property (lead_edge && !hold_act |=> gen_cnt_q == 8'h00)
    else $error("generator did not resync on leading edge");
  chk_hold_keep: assert property (lead_edge && hold_act && !gen_wrap |=> gen_cnt_q == $past(gen_cnt_q) + 8'h01)
    else $error("generator resynced during holdover");
  chk_port_b_off: assert property ((!dual |-> !port_b_oe) and (!dual && tick |=> $stable(port_b)))
    else $error("port B driven in single mode");
  chk_first_to_a: assert property (s_line_start |=> !sel_b_q)
    else $error("first pixel after sync not on port A");
  chk_interleave_a: assert property (s_pick_a |=> port_a == $past(pixel_in))
    else $error("pixel picked for port A not presented");
  chk_strobe_half: assert property (dual && $past(dual) && tick |=> strobe_q != $past(strobe_q))
    else $error("strobe did not toggle per pixel in dual mode");
  chk_lsync_pulse: assert property (lead_d && lsync_wid_q != 8'h00 |=> line_sync_output == lsync_pol)
    else $error("line sync did not assert after leading edge");
  chk_ext_clamp: assert property (ext_clamp_en && $stable(ext_clamp_en) |=> clamp_window == $past(pin_s.clamp == clamp_sense))
    else $error("external clamp level not followed");
  chk_int_clamp: assert property (!ext_clamp_en && $stable(ext_clamp_en) |=> clamp_window == $past(int_clamp))
    else $error("clamp pin not ignored while disabled");
  chk_slicer_sel: assert property (slicer_sel && $stable(slicer_sel) |=> green_sync_slicer_output == $past(hs_prev_q))
    else $error("slicer output not the delayed sync");

endmodule

// file: bench/pixel_sink.sv
// Model of the downstream display controller that counts output strobe rises.
`timescale 1ns/100ps
module pixel_sink
  import pixel_port_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Strobe from the block
  input wire logic output_strobe_clock,
  // Count of strobe rises seen
  output int rises
);
  logic prev_q;

  // A real receiver latches on the rising strobe, so only rises are counted.
  always_ff @(posedge aclk) begin
    prev_q <= output_strobe_clock;
    if (output_strobe_clock && !prev_q) begin
      rises <= rises + 1;
    end
  end
endmodule

// file: bench/pixel_port_control_bench.sv
// Self-checking testbench of the pixel port control block.
`timescale 1ns/100ps
module pixel_port_control_bench;
  import pixel_port_pkg::*;
  logic aclk, aresetn, awv, wv, bready, arv, rready, awready, wready, bvalid, arready, rvalid;
  logic port_b_oe, stb, stb_n, lso, slo, ss, cw;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [1:0] bresp, rresp;
  pins_t pins;
  pixel_t pix, pa, pb;
  int rises, n_fail, n_tests;

  pixel_port_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins_in(pins), .pixel_in(pix), .port_a(pa), .port_b(pb), .port_b_oe(port_b_oe),
    .output_strobe_clock(stb), .output_strobe_clock_n(stb_n), .line_sync_output(lso),
    .green_sync_slicer_output(slo), .sample_strobe(ss), .clamp_window(cw));
  pixel_sink sink (.aclk(aclk), .output_strobe_clock(stb), .rises(rises));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // A new converter value every cycle makes each sampled pixel distinct.
  always @(posedge aclk) pix <= pix + 24'h01_0101;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic tmo(input string m);
    chk(1'b0, m);
    final_report;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    int k;
    bit done;
    @(posedge aclk);
    done = 0;
    awa <= {2'b00, i, 2'b00};
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1;
        bready <= 1'b0;
      end
    end
    if (!done) tmo("write hang");
    chk(bresp === RESP_OKAY, "write response");
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    int k;
    bit done;
    @(posedge aclk);
    done = 0;
    ara <= {2'b00, i, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50 && !done; k++) begin
      @(posedge aclk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!done) tmo("read hang");
  endtask

  task automatic tick(output pixel_t v, output int n);
    for (n = 1; n < 40; n++) begin
      @(posedge aclk);
      if (ss === 1'b1) break;
    end
    v = pix;
    if (n == 40) tmo("no pixel tick");
  endtask

  // One external clock edge of level lv, then the opposite edge must not sample.
  task automatic px(input logic lv, output pixel_t v, output int n);
    int k, extra;
    pins.ext_clock <= lv;
    tick(v, n);
    pins.ext_clock <= ~lv;
    extra = 0;
    for (k = 0; k < 8; k++) begin
      @(posedge aclk);
      extra += int'(ss === 1'b1);
    end
    chk(extra == 0, "wrong clock edge sampled");
  endtask

  task automatic meas(input bit sel, output int t);
    int k;
    bit on, act;
    t = 0;
    on = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge aclk);
      act = (sel ? cw : ~lso) === 1'b1;
      if (act) t += int'(ss === 1'b1);
      if (on && !act) break;
      on = on | act;
    end
    if (k == 200) tmo("window hang");
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ix[7] = '{IDX_SYNC_CFG, IDX_CONTROL, IDX_PHASE, IDX_PERIOD, IDX_CLAMP_DLY, IDX_CLAMP_DUR,
      IDX_LSYNC_WID};
    logic [7:0] ex[7] = '{8'h00, RST_CONTROL, 8'h00, RST_PERIOD, RST_CLAMP_DLY, RST_CLAMP_DUR, RST_LSYNC_WID};
    for (int k = 0; k < 7; k++) begin
      rd(ix[k], d, r);
      chk(d === {24'h00_0000, ex[k]} && r === RESP_OKAY, "reset value");
    end
    rd(IDX_CONTROL, d, r);
    chk(d[2] === 1'b0 && d[5] === 1'b1, "clamp enable or holdover sense");
    rd(8'h3F, d, r);
    chk(d === 32'h0000_0000 && r === RESP_SLVERR, "unmapped read");
    chk(port_b_oe === 1'b0 && lso === 1'b1, "idle outputs");
    $display("test regs done");
  endtask

  task automatic t_rate(input logic [7:0] ctl, input int per, input int exp_r);
    int k, t, r0;
    pixel_t v;
    wr(IDX_CONTROL, ctl);
    wr(IDX_PERIOD, per[7:0]);
    repeat (12) @(posedge aclk);
    r0 = rises;
    t = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      t += int'(ss === 1'b1);
    end
    chk(t == 40 / per, "pixel rate");
    chk(rises - r0 == exp_r, "strobe rate");
    chk(stb_n === ~stb, "strobe pair");
    tick(v, k);
    repeat (2) @(posedge aclk);
    if (!ctl[0]) chk(pa === v && port_b_oe === 1'b0, "single port data");
    $display("test rate done");
  endtask

  task automatic t_dual(input logic par);
    pixel_t v1, v2, v3, a0;
    int n;
    logic s0;
    pins.ext_clock <= 1'b0;
    wr(IDX_CONTROL, 8'h31 | {6'h00, par, 1'b0});
    pins.hsync <= 1'b1;
    repeat (6) @(posedge aclk);
    pins.hsync <= 1'b0;
    repeat (8) @(posedge aclk);
    a0 = pa;
    s0 = stb;
    px(1'b1, v1, n);
    chk(stb !== s0, "strobe toggle");
    if (par) chk(pa === a0, "A waits for pair");
    else chk(pa === v1, "first pixel on A");
    px(1'b1, v2, n);
    chk(pa === v1 && pb === v2 && port_b_oe === 1'b1, "second pixel on B");
    px(1'b1, v3, n);
    if (!par) chk(pa === v3 && pb === v2, "third pixel on A");
    $display("test dual done");
  endtask

  task automatic t_phase;
    pixel_t v;
    int n0, n3;
    wr(IDX_CONTROL, 8'h30);
    px(1'b1, v, n0);
    wr(IDX_PHASE, 8'h03);
    px(1'b1, v, n3);
    chk(n3 == n0 + 3 && pa === v, "phase shift");
    wr(IDX_PHASE, 8'h00);
    // Invert is only moved while no line is being captured.
    pins.invert <= 1'b1;
    repeat (6) @(posedge aclk);
    pins.ext_clock <= 1'b1;
    repeat (8) @(posedge aclk);
    px(1'b0, v, n0);
    chk(pa === v, "inverted clock sample");
    pins.invert <= 1'b0;
    $display("test phase done");
  endtask

  task automatic t_sync;
    int t;
    wr(IDX_CONTROL, 8'h20);
    wr(IDX_LSYNC_WID, 8'h03);
    wr(IDX_CLAMP_DLY, 8'h01);
    wr(IDX_CLAMP_DUR, 8'h02);
    wr(IDX_SYNC_CFG, 8'h80);
    pins.clamp <= 1'b1;
    // Let any clamp window left over from the earlier tests run out first.
    repeat (40) @(posedge aclk);
    chk(cw === 1'b0 && lso === 1'b1, "clamp pin ignored");
    pins.hsync <= 1'b1;
    meas(1'b0, t);
    chk(t >= 2 && t <= 4, "line sync width");
    pins.hsync <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(lso === 1'b1, "trailing edge ignored");
    meas(1'b1, t);
    chk(t >= 1 && t <= 3, "internal clamp width");
    $display("test sync done");
  endtask

  task automatic t_clamp;
    wr(IDX_CONTROL, 8'h2C);
    repeat (6) @(posedge aclk);
    chk(cw === 1'b1, "high clamp pin");
    pins.clamp <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(cw === 1'b0, "clamp released");
    wr(IDX_CONTROL, 8'h24);
    repeat (6) @(posedge aclk);
    chk(cw === 1'b1, "low clamp sense");
    wr(IDX_CONTROL, 8'h20);
    repeat (6) @(posedge aclk);
    chk(cw === 1'b0, "clamp disabled");
    $display("test clamp done");
  endtask

  task automatic t_misc;
    logic [31:0] d;
    logic [1:0] r;
    pins.holdover <= 1'b1;
    pins.green_sync <= 1'b1;
    // A leading edge inside holdover must leave the generator running on.
    pins.hsync <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(IDX_STATUS, d, r);
    chk(d[2] === 1'b1 && slo === 1'b1, "holdover on, comparator out");
    pins.hsync <= 1'b0;
    wr(IDX_CONTROL, 8'h40);
    repeat (6) @(posedge aclk);
    rd(IDX_STATUS, d, r);
    chk(d[2] === 1'b0 && slo === 1'b0, "holdover off, raw sync out");
    wr(IDX_CONTROL, 8'hC0);
    chk(lso === 1'b0, "line sync idle level with polarity set");
    $display("test misc done");
  endtask

  initial begin
    {aresetn, awv, wv, bready, arv, rready, awa, ara, wd} = '0;
    pins = '0;
    pix = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_rate(8'h20, 2, 20);
    t_rate(8'h21, 4, 5);
    t_rate(8'h20, 4, 10);
    t_dual(1'b0);
    t_dual(1'b1);
    t_phase;
    t_sync;
    t_clamp;
    t_misc;
    final_report;
  end
endmodule
